// *** rtl/dms_sequencer.sv ***
`timescale 1ns/1ps
// Functional notes
// R1 - mode 0 outputs single tone frequency
// R2 - mode 1 key high second, low first
// R3 - fsk switch keeps phase continuous
// R4 - keying supported up to 15MHz
// R5 - undriven key reads as high
// R6 - mode 2 ramps first to second and back
// R7 - dwell is dwell count plus one clocks
// R8 - host sets repeat for aligned trigger
// R9 - repeat count accepts 5 to 2^32-1
// R10 - inexact counts let trigger drift
// R11 - mode 2 ramp ignores repeat count
// R12 - mode write starts output immediately
// R13 - mode 3 sawtooth resets at repeat time
// R14 - repeat time 2*(repeat+1) clocks
// R15 - chirp trigger pin pulses 8 clocks
// R16 - host holds key low in mode 3
// R17 - dwell count accepts 1 to 2^20-1
// R18 - frequency step 1uHz per unit
// R19 - mode 4 phase keyed, frequency first
// R20 - serial control only permits mode 0
// R21 - pll multiplier resets to 10
// R22 - host writes parameters under mode 0
module dms_sequencer
	import dms_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	input  wire logic                key_select,
	input  wire logic                key_driven,
	input  wire logic                serial_only,
	input  wire logic [11:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [11:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [FREQ_W-1:0]        freq_word,
	output logic [PHASE_W-1:0]       phase_word,
	output logic [PLL_W-1:0]         pll_multiplier,
	output logic                     update_trigger_pin,
	output logic                     update_trigger_pin_oe_n
);
	logic [2:0]          mode_q;
	logic [FREQ_W-1:0]   single_tone_frequency;
	logic [FREQ_W-1:0]   first_frequency;
	logic [FREQ_W-1:0]   second_frequency;
	logic [FREQ_W-1:0]   frequency_step;
	logic [DWELL_W-1:0]  dwell_count;
	logic [REPEAT_W-1:0] repeat_count;
	logic [PHASE_W-1:0]  first_phase_offset;
	logic [PHASE_W-1:0]  second_phase_offset;
	logic [PLL_W-1:0]    pll_q;
	logic                restart_q;
	logic                aw_q;
	logic                w_q;
	logic [11:0]         awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic [FREQ_W-1:0]   ramp_q;
	logic                down_q;
	logic                dwell_tick;
	logic                half_tick;
	logic                half_q;
	logic [3:0]          pulse_q;
	logic                key_hi;
	logic                do_write;
	logic                wr_ok;
	logic [31:0]         rd_val;
	logic                rd_ok;

	// floating key pin pulls up [R5]
	assign key_hi   = key_driven ? key_select : 1'b1;
	assign do_write = aw_q && w_q && !s_axi_bvalid;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// write address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_ok = 1'b1;
		case (awaddr_q)
			A_MODE, A_F0_LO, A_F0_HI, A_F1_LO, A_F1_HI, A_F2_LO, A_F2_HI,
			A_FD_LO, A_FD_HI, A_DWELL, A_REPEAT, A_PHASE, A_PLL: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// parameter registers; step lsb is one microhertz at default clock [R18]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q                <= MODE_RST[2:0];
			single_tone_frequency <= '0;
			first_frequency       <= '0;
			second_frequency      <= '0;
			frequency_step        <= '0;
			dwell_count           <= DWELL_RST;
			repeat_count          <= REPEAT_RST;
			first_phase_offset    <= '0;
			second_phase_offset   <= '0;
			pll_q                 <= PLL_MULT_RST; // [R21]
			restart_q             <= 1'b1;
		end else if (ce) begin
			restart_q <= 1'b0;
			if (do_write) begin
				case (awaddr_q)
					A_MODE: begin
						// mode write restarts the sequence at once [R12]
						restart_q <= 1'b1;
						// serial-only build locks mode 0 [R20]
						if (serial_only || wdata_q[2:0] > DMS_BPSK)
							mode_q <= DMS_TONE;
						else
							mode_q <= wdata_q[2:0];
					end
					A_F0_LO: single_tone_frequency[31:0] <= merge(single_tone_frequency[31:0],
						wdata_q, wstrb_q);
					A_F0_HI: single_tone_frequency[47:32] <= 16'(merge({16'h0000,
						single_tone_frequency[47:32]}, wdata_q, wstrb_q));
					A_F1_LO: first_frequency[31:0] <= merge(first_frequency[31:0], wdata_q,
						wstrb_q);
					A_F1_HI: first_frequency[47:32] <= wdata_q[15:0];
					A_F2_LO: second_frequency[31:0] <= merge(second_frequency[31:0], wdata_q,
						wstrb_q);
					A_F2_HI: second_frequency[47:32] <= wdata_q[15:0];
					A_FD_LO: frequency_step[31:0] <= merge(frequency_step[31:0], wdata_q,
						wstrb_q);
					A_FD_HI: frequency_step[47:32] <= wdata_q[15:0];
					// zero dwell clamps to shortest legal value [R17]
					A_DWELL: dwell_count <= (wdata_q[19:0] == 20'h00000) ? DWELL_RST
						: wdata_q[19:0];
					// below 5 clamps to 5 [R9]
					A_REPEAT: repeat_count <= (wdata_q < REPEAT_RST) ? REPEAT_RST : wdata_q;
					A_PHASE: begin
						first_phase_offset  <= wdata_q[13:0];
						second_phase_offset <= wdata_q[29:16];
					end
					A_PLL: pll_q <= wdata_q[4:0];
					default: ;
				endcase
			end
		end
	end

	always_comb begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case (s_axi_araddr)
			A_MODE:   rd_val = {29'h0, mode_q};
			A_F0_LO:  rd_val = single_tone_frequency[31:0];
			A_F0_HI:  rd_val = {16'h0000, single_tone_frequency[47:32]};
			A_F1_LO:  rd_val = first_frequency[31:0];
			A_F1_HI:  rd_val = {16'h0000, first_frequency[47:32]};
			A_F2_LO:  rd_val = second_frequency[31:0];
			A_F2_HI:  rd_val = {16'h0000, second_frequency[47:32]};
			A_FD_LO:  rd_val = frequency_step[31:0];
			A_FD_HI:  rd_val = {16'h0000, frequency_step[47:32]};
			A_DWELL:  rd_val = {12'h000, dwell_count};
			A_REPEAT: rd_val = repeat_count;
			A_PHASE:  rd_val = {2'b00, second_phase_offset, 2'b00, first_phase_offset};
			A_PLL:    rd_val = {27'h0, pll_q};
			A_STATUS: rd_val = {27'h0, update_trigger_pin, down_q, key_hi, 2'b00};
			default:  rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// dwell interval is dwell count + 1 clocks [R7]
	dms_tick #(.W(DWELL_W)) u_dwell (
		.aclk  (aclk),
		.clr   (!aresetn || (restart_q && ce)),
		.ce    (ce),
		.limit (dwell_count),
		.tick  (dwell_tick)
	);

	// half repeat time; two halves give 2*(repeat+1) clocks [R14]
	dms_tick #(.W(REPEAT_W)) u_repeat (
		.aclk  (aclk),
		.clr   (!aresetn || (restart_q && ce)),
		.ce    (ce),
		.limit (repeat_count),
		.tick  (half_tick)
	);

	// mode 2 ramp runs from the dwell tick only, repeat never gates it [R11]
	always_ff @(posedge aclk) begin
		if (!aresetn || (restart_q && ce)) begin
			ramp_q <= first_frequency;
			down_q <= 1'b0;
			half_q <= 1'b0;
		end else if (ce) begin
			if (half_tick)
				half_q <= !half_q;
			if (mode_q == DMS_RAMP && dwell_tick) begin // [R6]
				if (!down_q) begin
					if (ramp_q + frequency_step >= second_frequency) begin
						ramp_q <= second_frequency;
						down_q <= 1'b1;
					end else begin
						ramp_q <= ramp_q + frequency_step;
					end
				end else begin
					if (ramp_q <= first_frequency + frequency_step) begin
						ramp_q <= first_frequency;
						down_q <= 1'b0;
					end else begin
						ramp_q <= ramp_q - frequency_step;
					end
				end
			end else if (mode_q == DMS_CHIRP) begin
				// sawtooth back to start at repeat expiry [R13]
				if (half_tick && half_q)
					ramp_q <= first_frequency;
				else if (dwell_tick && !key_hi) // key must be low [R16]
					ramp_q <= ramp_q + frequency_step;
			end
		end
	end

	// trigger is free-running from repeat counter, so inexact counts slide [R10] [R8]
	always_ff @(posedge aclk) begin
		// a started pulse runs out across a mode write, so no runt reaches the pin
		if (!aresetn) begin
			pulse_q <= '0;
		end else if (ce) begin
			if (half_tick && half_q && (mode_q == DMS_CHIRP || mode_q == DMS_RAMP))
				pulse_q <= 4'(PULSE_CYC);
			else if (pulse_q != 4'h0)
				pulse_q <= pulse_q - 4'h1;
		end
	end

	// output words; outside mode 4 only the increment word changes, so the phase stays continuous [R3]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_word               <= '0;
			phase_word              <= '0;
			pll_multiplier          <= PLL_MULT_RST;
			update_trigger_pin      <= 1'b0;
			update_trigger_pin_oe_n <= 1'b1;
		end else if (ce) begin
			pll_multiplier <= pll_q;
			phase_word     <= '0;
			// chirp and ramp modes drive trigger pin, 8-clock pulses [R15]
			update_trigger_pin_oe_n <= !(mode_q == DMS_CHIRP || mode_q == DMS_RAMP
				|| pulse_q != 4'h0);
			update_trigger_pin      <= (pulse_q != 4'h0);
			case (mode_q)
				DMS_TONE:  freq_word <= single_tone_frequency; // [R1]
				// sampled every clock, far above 15MHz keying [R4]
				DMS_FSK:   freq_word <= key_hi ? second_frequency : first_frequency; // [R2]
				DMS_RAMP:  freq_word <= ramp_q;
				DMS_CHIRP: freq_word <= ramp_q;
				DMS_BPSK: begin
					freq_word  <= first_frequency; // [R19]
					phase_word <= key_hi ? second_phase_offset : first_phase_offset;
				end
				default:   freq_word <= single_tone_frequency;
			endcase
		end
	end
endmodule // dms_sequencer

// *** rtl/dms_pkg.sv ***
package dms_pkg;
	localparam int FREQ_W      = 48;
	localparam int PHASE_W     = 14;
	localparam int DWELL_W     = 20;
	localparam int REPEAT_W    = 32;
	localparam int PLL_W       = 5;
	localparam int PULSE_CYC   = 8;
	localparam logic [PLL_W-1:0] PLL_MULT_RST = 5'h0a;
	localparam logic [11:0] A_MODE   = 12'h000;
	localparam logic [11:0] A_F0_LO  = 12'h004;
	localparam logic [11:0] A_F0_HI  = 12'h008;
	localparam logic [11:0] A_F1_LO  = 12'h00c;
	localparam logic [11:0] A_F1_HI  = 12'h010;
	localparam logic [11:0] A_F2_LO  = 12'h014;
	localparam logic [11:0] A_F2_HI  = 12'h018;
	localparam logic [11:0] A_FD_LO  = 12'h01c;
	localparam logic [11:0] A_FD_HI  = 12'h020;
	localparam logic [11:0] A_DWELL  = 12'h024;
	localparam logic [11:0] A_REPEAT = 12'h028;
	localparam logic [11:0] A_PHASE  = 12'h02c;
	localparam logic [11:0] A_PLL    = 12'h030;
	localparam logic [11:0] A_STATUS = 12'h034;
	localparam logic [31:0] MODE_RST   = 32'h0000_0000;
	localparam logic [19:0] DWELL_RST  = 20'h00001;
	localparam logic [31:0] REPEAT_RST = 32'h0000_0005;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		DMS_TONE  = 3'b000,
		DMS_FSK   = 3'b001,
		DMS_RAMP  = 3'b010,
		DMS_CHIRP = 3'b011,
		DMS_BPSK  = 3'b100
	} dms_mode_e;
endpackage

// *** rtl/dms_tick.sv ***
`timescale 1ns/1ps
module dms_tick
	import dms_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic         aclk,
	input  wire logic         clr,
	input  wire logic         ce,
	input  wire logic [W-1:0] limit,
	output logic              tick
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge aclk) begin
		if (clr) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (ce) begin
			tick <= (cnt_q >= limit);
			if (cnt_q >= limit)
				cnt_q <= '0;
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // dms_tick

// *** verif/dms_checker.sv ***
`timescale 1ns/1ps
module dms_checker
	import dms_pkg::*;
(
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               ce,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic [1:0]         s_axi_bresp,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready,
	input wire logic [FREQ_W-1:0]  freq_word,
	input wire logic [PLL_W-1:0]   pll_multiplier,
	input wire logic               update_trigger_pin,
	input wire logic               update_trigger_pin_oe_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!ce);
	chk_pll_reset: assert property (!aresetn |=> pll_multiplier == PLL_MULT_RST)
		else $error("pll multiplier off its reset value");
	chk_reset_idle: assert property (!aresetn |=> !s_axi_bvalid && !s_axi_rvalid
		&& freq_word == '0 && update_trigger_pin_oe_n)
		else $error("outputs not idle in reset");
	chk_trig_width: assert property (disable iff (!aresetn || !ce)
		$rose(update_trigger_pin) |-> update_trigger_pin[*8] ##1 !update_trigger_pin)
		else $error("trigger pulse width wrong");
	chk_trig_drive: assert property (update_trigger_pin |-> !update_trigger_pin_oe_n)
		else $error("trigger high while pin not driven");
	chk_trig_gap: assert property ($fell(update_trigger_pin) |-> !update_trigger_pin[*4])
		else $error("trigger period shorter than minimum repeat");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
		else $error("read answer late");
	cover property ($rose(update_trigger_pin));
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule // dms_checker
bind dms_sequencer dms_checker i_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .freq_word(freq_word),
	.pll_multiplier(pll_multiplier), .update_trigger_pin(update_trigger_pin),
	.update_trigger_pin_oe_n(update_trigger_pin_oe_n));

// *** verif/dms_key_host.sv ***
`timescale 1ns/1ps
module dms_key_host (
	input  wire logic aclk,
	input  wire logic want_level,
	input  wire logic want_float,
	output logic      key_select,
	output logic      key_driven
);
	logic lvl_q;
	int   gap_q;
	initial begin
		lvl_q = 1'b0;
		gap_q = 0;
		key_select = 1'b0;
		key_driven = 1'b1;
	end
	always @(posedge aclk) begin
		// slow host: no change sooner than 5 cycles, well under 15MHz
		if (gap_q > 0)
			gap_q <= gap_q - 1;
		else if ({want_float, want_level} != {!key_driven, lvl_q}) begin
			lvl_q <= want_level;
			key_driven <= !want_float;
			gap_q <= 4;
		end
		// released line shows a moving pattern, not the last level
		if (!key_driven)
			key_select <= !key_select;
		else
			key_select <= lvl_q;
	end
endmodule // dms_key_host

// *** verif/dms_sequencer_test.sv ***
`timescale 1ns/1ps
module dms_sequencer_test
	import dms_pkg::*;
;
	typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} dms_row_s;
	localparam logic [47:0] F1 = 48'h100, FD = 48'h10, F2 = 48'h130;
	logic aclk = 0, aresetn = 0, ce = 1, serial_only = 0, want_level = 0, want_float = 0;
	logic key_select, key_driven, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_rvalid, update_trigger_pin, update_trigger_pin_oe_n;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [FREQ_W-1:0] freq_word;
	logic [PHASE_W-1:0] phase_word;
	logic [PLL_W-1:0] pll_multiplier;
	logic [31:0] d;
	int error_cnt = 0, comparisons = 0, n;
	dms_row_s rows[7] = '{'{A_F0_LO, 32'h1234_5678, 32'h1234_5678, RESP_OKAY},
		'{A_F0_HI, 32'h0000_00a5, 32'h0000_00a5, RESP_OKAY},
		'{A_DWELL, 32'h0, 32'h1, RESP_OKAY}, '{A_DWELL, 32'hf_ffff, 32'hf_ffff, RESP_OKAY},
		'{A_REPEAT, 32'h4, 32'h5, RESP_OKAY}, '{A_REPEAT, '1, '1, RESP_OKAY},
		'{12'h040, 32'h1, 32'h0, RESP_SLVERR}};
	dms_sequencer i_dut (.*);
	dms_key_host i_host (.aclk(aclk), .want_level(want_level), .want_float(want_float),
		.key_select(key_select), .key_driven(key_driven));
	always #4 aclk = !aclk;
	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge aclk);
		#1;
	endtask
	task automatic wt_f(input logic [47:0] v);
		n = 0;
		do begin
			wt(1);
			n++;
		end while (freq_word !== v && n < 64);
	endtask
	task automatic wt_rise();
		logic p;
		n = 0;
		do begin
			p = update_trigger_pin;
			wt(1);
			n++;
		end while (!(update_trigger_pin === 1'b1 && p === 1'b0) && n < 64);
	endtask
	task automatic close_out();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		wt(20000);
		error_cnt++;
		close_out();
	end
	initial begin
		wt(5);
		aresetn <= 1'b1;
		wt(1);
		chk("pll", pll_multiplier, PLL_MULT_RST);
		chk("oe_n", update_trigger_pin_oe_n, 1'b1);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			chk("bresp", r, rows[i].r);
			rd(rows[i].a);
			chk("rdata", d, rows[i].e);
			chk("rresp", r, rows[i].r);
		end
		wr(A_MODE, 32'h0);
		wt(3);
		chk("tone", freq_word, 48'h00a5_1234_5678);
		wr(A_F1_LO, F1[31:0]);
		wr(A_F2_LO, F2[31:0]);
		wr(A_FD_LO, FD[31:0]);
		wr(A_PHASE, 32'h0155_0aaa);
		wr(A_MODE, 32'h1);
		wt(8);
		chk("fsk low", freq_word, F1);
		want_level <= 1'b1;
		wt(8);
		chk("fsk high", freq_word, F2);
		chk("fsk phase", phase_word, 14'h0000);
		want_level <= 1'b0;
		wt(8);
		want_float <= 1'b1;
		wt(8);
		chk("fsk float", freq_word, F2);
		wr(A_MODE, 32'h4);
		wt(8);
		chk("bpsk phase", phase_word, 14'h0155);
		chk("bpsk freq", freq_word, F1);
		want_float <= 1'b0;
		wt(8);
		chk("bpsk low", phase_word, 14'h0aaa);
		wr(A_MODE, 32'h0);
		wr(A_DWELL, 32'h2);
		wr(A_MODE, 32'h2);
		wt_f(F1 + FD);
		wt_f(F1 + 2 * FD);
		chk("dwell", n, 3);
		wt_f(F2);
		wt_f(F2 - FD);
		chk("turn", n, 3);
		chk("oe ramp", update_trigger_pin_oe_n, 1'b0);
		ce <= 1'b0;
		wt(10);
		chk("ce hold", freq_word, F2 - FD);
		ce <= 1'b1;
		wr(A_MODE, 32'h0);
		wr(A_REPEAT, 32'h5);
		wr(A_DWELL, 32'h1);
		wr(A_MODE, 32'h3); // key held low
		wt_rise();
		wt_rise();
		chk("period", n, 12);
		wt_f(F1 + FD);
		wt_f(F1);
		chk("saw back", n < 13, 1'b1);
		serial_only <= 1'b1;
		wr(A_MODE, 32'h2);
		rd(A_MODE);
		chk("serial mode", d, 32'h0);
		wr(A_PLL, 32'h3);
		wt(2);
		chk("pll set", pll_multiplier, 5'h03);
		aresetn <= 1'b0;
		wt(2);
		aresetn <= 1'b1;
		wt(1);
		chk("pll again", pll_multiplier, PLL_MULT_RST);
		rd(A_F0_LO);
		chk("tone rst", d, 32'h0);
		close_out();
	end
endmodule // dms_sequencer_test
